/* smie_pkg.sv */
// Constants for the shift, move and indirect load execution block
package smie_pkg;
	// Widths
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int PTR_W = 16;
	localparam int BANK_W = 5;
	localparam int FADDR_W = 7;
	localparam int LATCH_W = 7;
	localparam int OFS_W = 6;
	localparam int MM_W = 2;
	localparam int OP_W = 3;
	localparam int MEM_AW = BANK_W + FADDR_W;
	localparam int HADDR_W = 8;

	// Register byte offsets
	localparam logic [HADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [HADDR_W-1:0] REG_ACC = 8'h04;
	localparam logic [HADDR_W-1:0] REG_BANK = 8'h08;
	localparam logic [HADDR_W-1:0] REG_LATCH = 8'h0c;
	localparam logic [HADDR_W-1:0] REG_PTR0 = 8'h10;
	localparam logic [HADDR_W-1:0] REG_PTR1 = 8'h14;
	localparam logic [HADDR_W-1:0] REG_STATUS = 8'h18;
	localparam logic [HADDR_W-1:0] REG_MEMADDR = 8'h1c;
	localparam logic [HADDR_W-1:0] REG_MEMDATA = 8'h20;

	// Command word field positions
	localparam int CMD_K_LSB = 0;
	localparam int CMD_D_BIT = 8;
	localparam int CMD_N_BIT = 9;
	localparam int CMD_MM_LSB = 10;
	localparam int CMD_OFS_LSB = 12;
	localparam int CMD_OP_LSB = 20;

	// Command codes
	localparam logic [OP_W-1:0] OP_NONE = 3'h0;
	localparam logic [OP_W-1:0] OP_LSR = 3'h1;
	localparam logic [OP_W-1:0] OP_MOVE = 3'h2;
	localparam logic [OP_W-1:0] OP_IND_LOAD = 3'h3;
	localparam logic [OP_W-1:0] OP_IND_REL = 3'h4;
	localparam logic [OP_W-1:0] OP_BANK_LIT = 3'h5;
	localparam logic [OP_W-1:0] OP_LATCH_LIT = 3'h6;
	localparam logic [OP_W-1:0] OP_ACC_LIT = 3'h7;

	// Pointer update mode codes
	localparam logic [MM_W-1:0] MM_PRE_INC = 2'h0;
	localparam logic [MM_W-1:0] MM_PRE_DEC = 2'h1;
	localparam logic [MM_W-1:0] MM_POST_INC = 2'h2;
	localparam logic [MM_W-1:0] MM_POST_DEC = 2'h3;

	// Status bit positions
	localparam int ST_C_BIT = 0;
	localparam int ST_Z_BIT = 1;
	localparam int ST_BUSY_BIT = 2;

	// Indirect window file addresses
	localparam logic [FADDR_W-1:0] WIN0_ADDR = 7'h00;
	localparam logic [FADDR_W-1:0] WIN1_ADDR = 7'h01;

	// Pointer step and bus codes
	localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
	localparam int HTRANS_ACT_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

	// Reset values
	localparam logic [BYTE_W-1:0] ACC_RST = 8'h00;
	localparam logic [BANK_W-1:0] BANK_RST = 5'h00;
	localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
	localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
	localparam logic [MEM_AW-1:0] MEMADDR_RST = 12'h000;
endpackage : smie_pkg

/* smie_filemem.sv */
// File register space memory with registered read data
module smie_filemem #(
	parameter int unsigned AW = 12,
	parameter int unsigned DW = 8
) (
	input wire logic clock_i, // Core clock
	input wire logic we_i, // Write strobe
	input wire logic [AW-1:0] waddr_i, // Write address
	input wire logic [DW-1:0] wdata_i, // Write data
	input wire logic re_i, // Read strobe
	input wire logic [AW-1:0] raddr_i, // Read address
	output logic [DW-1:0] rdata_o // Read data, one cycle after strobe
);
	logic [DW-1:0] mem_q [2**AW];
	logic [DW-1:0] rdata_q;

	// Storage array and read register
	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem_q[waddr_i] <= wdata_i;
		end
		if (re_i) begin
			rdata_q <= mem_q[raddr_i];
		end
	end

	assign rdata_o = rdata_q;
endmodule : smie_filemem

/* smie_core.sv */
// Execution datapath for shift, move, indirect load and literal loads
// Operation
// - Right shift: bit0 to carry, zero into bit7
// - Shift result to accumulator or back to file
// - Move copies file to accumulator or itself
// - Move updates zero flag from moved value
// - Indirect address: pointer+1, -1, +offset or unmodified
// - Pointer left +1, -1, or unchanged for offset
// - Offset spans -32..31; two pointers selectable
// - Window address redirects to pointed location
// - Pointer is 16 bits and wraps
// - Bank literal five-bit field into bank select
// - Seven-bit literal into program counter high latch
// - High latch load leaves flags alone
// - Eight-bit literal loads the accumulator
// - Accumulator literal load leaves flags alone
module smie_core (
	input wire logic clock_i, // Core clock, 40 MHz
	input wire logic rst_n_i, // Asynchronous reset, active low
	input wire logic hsel_i, // AHB slave select
	input wire logic [smie_pkg::HADDR_W-1:0] haddr_i, // AHB address
	input wire logic [1:0] htrans_i, // AHB transfer type
	input wire logic hwrite_i, // AHB write
	input wire logic [2:0] hsize_i, // AHB size, word only
	input wire logic [smie_pkg::DATA_W-1:0] hwdata_i, // AHB write data
	input wire logic hready_i, // AHB bus ready
	output logic [smie_pkg::DATA_W-1:0] hrdata_o, // AHB read data
	output logic hreadyout_o, // AHB slave ready
	output logic hresp_o, // AHB response, always OKAY
	output logic [smie_pkg::BYTE_W-1:0] acc_o, // Accumulator
	output logic [smie_pkg::BANK_W-1:0] bank_select_register_o, // Bank select
	output logic [smie_pkg::LATCH_W-1:0] program_counter_high_latch_o, // High latch
	output logic carry_o, // Carry flag
	output logic zero_o // Zero flag
);
	import smie_pkg::*;

	typedef enum logic [1:0] {
		BS_IDLE,
		BS_WAIT,
		BS_MEM,
		BS_DONE
	} smie_bus_state_t;

	typedef enum logic [1:0] {
		EX_IDLE,
		EX_RD,
		EX_WB
	} smie_ex_state_t;

	smie_bus_state_t bus_q, bus_d;
	smie_ex_state_t ex_q, ex_d;
	logic [HADDR_W-1:0] baddr_q, baddr_d;
	logic bwr_q, bwr_d;
	logic hready_q, hready_d;
	logic [DATA_W-1:0] hrdata_q, hrdata_d;
	logic hresp_q;
	logic [BYTE_W-1:0] acc_q, acc_d;
	logic [BANK_W-1:0] bank_q, bank_d;
	logic [LATCH_W-1:0] latch_q, latch_d;
	logic [PTR_W-1:0] ptr0_q, ptr0_d;
	logic [PTR_W-1:0] ptr1_q, ptr1_d;
	logic carry_q, carry_d;
	logic zero_q, zero_d;
	logic [MEM_AW-1:0] memaddr_q, memaddr_d;
	logic [OP_W-1:0] ex_op_q, ex_op_d;
	logic ex_dest_q, ex_dest_d;
	logic [MEM_AW-1:0] ex_addr_q, ex_addr_d;

	logic accept;
	logic busy;
	logic [OP_W-1:0] cmd_op;
	logic [FADDR_W-1:0] cmd_f;
	logic cmd_d;
	logic cmd_n;
	logic [MM_W-1:0] cmd_mm;
	logic [OFS_W-1:0] cmd_ofs;
	logic [PTR_W-1:0] sel_ptr;
	logic [PTR_W-1:0] ptr_inc;
	logic [PTR_W-1:0] ptr_dec;
	logic [PTR_W-1:0] ofs_ext;
	logic [PTR_W-1:0] ptr_rel;
	logic [MEM_AW-1:0] file_addr;
	logic [BYTE_W-1:0] lsr_res;
	logic [BYTE_W-1:0] wb_res;
	logic wb_zero;
	logic [DATA_W-1:0] rd_val;
	logic mem_we;
	logic [MEM_AW-1:0] mem_waddr;
	logic [BYTE_W-1:0] mem_wdata;
	logic mem_re;
	logic [MEM_AW-1:0] mem_raddr;
	logic [BYTE_W-1:0] mem_rdata;

	// File register space
	smie_filemem #(
		.AW(MEM_AW),
		.DW(BYTE_W)
	) u_filemem (
		.clock_i(clock_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.re_i(mem_re),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);

	// Bus qualifiers
	assign accept = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;
	assign busy = (ex_q != EX_IDLE);

	// Command word fields, taken in the write data phase
	assign cmd_op = hwdata_i[CMD_OP_LSB +: OP_W];
	assign cmd_f = hwdata_i[CMD_K_LSB +: FADDR_W];
	assign cmd_d = hwdata_i[CMD_D_BIT];
	assign cmd_n = hwdata_i[CMD_N_BIT];
	assign cmd_mm = hwdata_i[CMD_MM_LSB +: MM_W];
	assign cmd_ofs = hwdata_i[CMD_OFS_LSB +: OFS_W];

	// Pointer arithmetic, modulo 2^16
	assign sel_ptr = cmd_n ? ptr1_q : ptr0_q;
	assign ptr_inc = PTR_W'(sel_ptr + PTR_STEP);
	assign ptr_dec = PTR_W'(sel_ptr - PTR_STEP);
	assign ofs_ext = {{(PTR_W - OFS_W){cmd_ofs[OFS_W-1]}}, cmd_ofs};
	assign ptr_rel = PTR_W'(sel_ptr + ofs_ext);

	// File address, window locations follow their pointer
	always_comb begin
		if (cmd_f == WIN0_ADDR) begin
			file_addr = ptr0_q[MEM_AW-1:0];
		end else if (cmd_f == WIN1_ADDR) begin
			file_addr = ptr1_q[MEM_AW-1:0];
		end else begin
			file_addr = {bank_q, cmd_f};
		end
	end

	// Write-back value and its zero test
	assign lsr_res = {1'b0, mem_rdata[BYTE_W-1:1]};
	assign wb_res = (ex_op_q == OP_LSR) ? lsr_res : mem_rdata;
	assign wb_zero = (wb_res == '0);

	// Register read mux, unmapped reads as zero
	always_comb begin
		rd_val = '0;
		case (baddr_q)
			REG_ACC: rd_val[BYTE_W-1:0] = acc_q;
			REG_BANK: rd_val[BANK_W-1:0] = bank_q;
			REG_LATCH: rd_val[LATCH_W-1:0] = latch_q;
			REG_PTR0: rd_val[PTR_W-1:0] = ptr0_q;
			REG_PTR1: rd_val[PTR_W-1:0] = ptr1_q;
			REG_STATUS: begin
				rd_val[ST_C_BIT] = carry_q;
				rd_val[ST_Z_BIT] = zero_q;
				rd_val[ST_BUSY_BIT] = busy;
			end
			REG_MEMADDR: rd_val[MEM_AW-1:0] = memaddr_q;
			default: rd_val = '0;
		endcase
	end

	// Next state of bus slave, registers and execution sequencer
	always_comb begin
		bus_d = bus_q;
		ex_d = ex_q;
		baddr_d = baddr_q;
		bwr_d = bwr_q;
		hready_d = hready_q;
		hrdata_d = hrdata_q;
		acc_d = acc_q;
		bank_d = bank_q;
		latch_d = latch_q;
		ptr0_d = ptr0_q;
		ptr1_d = ptr1_q;
		carry_d = carry_q;
		zero_d = zero_q;
		memaddr_d = memaddr_q;
		ex_op_d = ex_op_q;
		ex_dest_d = ex_dest_q;
		ex_addr_d = ex_addr_q;
		mem_we = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;
		mem_re = 1'b0;
		mem_raddr = '0;

		// Bus slave: one wait state, two for memory data reads, more while executing
		case (bus_q)
			BS_IDLE, BS_DONE: begin
				hready_d = 1'b1;
				bus_d = BS_IDLE;
				if (accept) begin
					bus_d = BS_WAIT;
					hready_d = 1'b0;
					baddr_d = haddr_i;
					bwr_d = hwrite_i;
				end
			end
			BS_WAIT: begin
				if (!busy) begin
					if (bwr_q) begin
						bus_d = BS_DONE;
						hready_d = 1'b1;
						case (baddr_q)
							REG_CMD: begin
								case (cmd_op)
									OP_LSR, OP_MOVE: begin
										ex_op_d = cmd_op;
										ex_dest_d = cmd_d;
										ex_addr_d = file_addr;
										ex_d = EX_RD;
									end
									OP_IND_LOAD: begin
										ex_op_d = cmd_op;
										ex_dest_d = 1'b0;
										ex_d = EX_RD;
										case (cmd_mm)
											MM_PRE_INC: ex_addr_d = ptr_inc[MEM_AW-1:0];
											MM_PRE_DEC: ex_addr_d = ptr_dec[MEM_AW-1:0];
											default: ex_addr_d = sel_ptr[MEM_AW-1:0];
										endcase
										if (cmd_mm == MM_PRE_INC || cmd_mm == MM_POST_INC) begin
											if (cmd_n) begin
												ptr1_d = ptr_inc;
											end else begin
												ptr0_d = ptr_inc;
											end
										end else begin
											if (cmd_n) begin
												ptr1_d = ptr_dec;
											end else begin
												ptr0_d = ptr_dec;
											end
										end
									end
									OP_IND_REL: begin
										ex_op_d = cmd_op;
										ex_dest_d = 1'b0;
										ex_addr_d = ptr_rel[MEM_AW-1:0];
										ex_d = EX_RD;
									end
									OP_BANK_LIT: begin
										bank_d = hwdata_i[CMD_K_LSB +: BANK_W];
									end
									OP_LATCH_LIT: begin
										latch_d = hwdata_i[CMD_K_LSB +: LATCH_W];
									end
									OP_ACC_LIT: begin
										acc_d = hwdata_i[CMD_K_LSB +: BYTE_W];
									end
									default: ex_d = EX_IDLE;
								endcase
							end
							REG_ACC: acc_d = hwdata_i[BYTE_W-1:0];
							REG_BANK: bank_d = hwdata_i[BANK_W-1:0];
							REG_LATCH: latch_d = hwdata_i[LATCH_W-1:0];
							REG_PTR0: ptr0_d = hwdata_i[PTR_W-1:0];
							REG_PTR1: ptr1_d = hwdata_i[PTR_W-1:0];
							REG_STATUS: begin
								carry_d = hwdata_i[ST_C_BIT];
								zero_d = hwdata_i[ST_Z_BIT];
							end
							REG_MEMADDR: memaddr_d = hwdata_i[MEM_AW-1:0];
							REG_MEMDATA: begin
								mem_we = 1'b1;
								mem_waddr = memaddr_q;
								mem_wdata = hwdata_i[BYTE_W-1:0];
							end
							default: bus_d = BS_DONE;
						endcase
					end else if (baddr_q == REG_MEMDATA) begin
						mem_re = 1'b1;
						mem_raddr = memaddr_q;
						bus_d = BS_MEM;
					end else begin
						hrdata_d = rd_val;
						bus_d = BS_DONE;
						hready_d = 1'b1;
					end
				end
			end
			BS_MEM: begin
				hrdata_d = {{(DATA_W - BYTE_W){1'b0}}, mem_rdata};
				bus_d = BS_DONE;
				hready_d = 1'b1;
			end
			default: begin
				bus_d = BS_IDLE;
				hready_d = 1'b1;
			end
		endcase

		// Execution: read the operand, then write back and set flags
		case (ex_q)
			EX_IDLE: ex_d = ex_d;
			EX_RD: begin
				mem_re = 1'b1;
				mem_raddr = ex_addr_q;
				ex_d = EX_WB;
			end
			EX_WB: begin
				ex_d = EX_IDLE;
				zero_d = wb_zero;
				if (ex_op_q == OP_LSR) begin
					carry_d = mem_rdata[0];
				end
				if ((ex_op_q == OP_LSR || ex_op_q == OP_MOVE) && ex_dest_q) begin
					mem_we = 1'b1;
					mem_waddr = ex_addr_q;
					mem_wdata = wb_res;
				end else begin
					acc_d = wb_res;
				end
			end
			default: ex_d = EX_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_q <= BS_IDLE;
			ex_q <= EX_IDLE;
			baddr_q <= '0;
			bwr_q <= 1'b0;
			hready_q <= 1'b1;
			hrdata_q <= '0;
			hresp_q <= HRESP_OKAY;
			acc_q <= ACC_RST;
			bank_q <= BANK_RST;
			latch_q <= LATCH_RST;
			ptr0_q <= PTR_RST;
			ptr1_q <= PTR_RST;
			carry_q <= 1'b0;
			zero_q <= 1'b0;
			memaddr_q <= MEMADDR_RST;
			ex_op_q <= OP_NONE;
			ex_dest_q <= 1'b0;
			ex_addr_q <= '0;
		end else begin
			bus_q <= bus_d;
			ex_q <= ex_d;
			baddr_q <= baddr_d;
			bwr_q <= bwr_d;
			hready_q <= hready_d;
			hrdata_q <= hrdata_d;
			hresp_q <= HRESP_OKAY;
			acc_q <= acc_d;
			bank_q <= bank_d;
			latch_q <= latch_d;
			ptr0_q <= ptr0_d;
			ptr1_q <= ptr1_d;
			carry_q <= carry_d;
			zero_q <= zero_d;
			memaddr_q <= memaddr_d;
			ex_op_q <= ex_op_d;
			ex_dest_q <= ex_dest_d;
			ex_addr_q <= ex_addr_d;
		end
	end

	// Outputs straight from flops
	assign hrdata_o = hrdata_q;
	assign hreadyout_o = hready_q;
	assign hresp_o = hresp_q;
	assign acc_o = acc_q;
	assign bank_select_register_o = bank_q;
	assign program_counter_high_latch_o = latch_q;
	assign carry_o = carry_q;
	assign zero_o = zero_q;
endmodule : smie_core

/* smie_core_asserts.sv */
// Port checker for the execution block
module smie_core_asserts (
	input wire logic clock_i, // Clock
	input wire logic rst_n_i, // Reset
	input wire logic hsel_i, // Select
	input wire logic [smie_pkg::HADDR_W-1:0] haddr_i, // Addr
	input wire logic [1:0] htrans_i, // Trans
	input wire logic hwrite_i, // Write
	input wire logic [smie_pkg::DATA_W-1:0] hwdata_i, // Data
	input wire logic hready_i, // Ready
	input wire logic hreadyout_o, // Slave ready
	input wire logic [smie_pkg::BYTE_W-1:0] acc_o, // Acc
	input wire logic [smie_pkg::BANK_W-1:0] bank_select_register_o, // Bank
	input wire logic [smie_pkg::LATCH_W-1:0] program_counter_high_latch_o, // Latch
	input wire logic carry_o, // Carry
	input wire logic zero_o // Zero
);
	timeunit 1ns;
	timeprecision 100ps;
	import smie_pkg::*;
	logic pend_q, cw_q, ok_q, c_q, z_q;
	logic [2:0] gap_q;
	wire take = hsel_i && htrans_i[HTRANS_ACT_BIT] && hready_i;
	wire done = pend_q && cw_q && hready_i;
	wire [OP_W-1:0] op = hwdata_i[CMD_OP_LSB+:OP_W];
	wire lit = op == OP_ACC_LIT || op == OP_LATCH_LIT;
	wire ind = op == OP_IND_LOAD || op == OP_IND_REL;
	wire d0 = !hwdata_i[CMD_D_BIT];
	// Command data phase, flags at accept, quiet gap after any command write
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q <= 1'b0;
			cw_q <= 1'b0;
			ok_q <= 1'b0;
			c_q <= 1'b0;
			z_q <= 1'b0;
			gap_q <= 3'h7;
		end else begin
			if (take) begin
				pend_q <= 1'b1;
				cw_q <= hwrite_i && haddr_i == REG_CMD;
				ok_q <= gap_q >= 3'h3;
				c_q <= carry_o;
				z_q <= zero_o;
			end else if (hready_i) begin
				pend_q <= 1'b0;
			end
			gap_q <= done ? 3'h0 : gap_q + {2'h0, gap_q != 3'h7};
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	AST_ACC: assert property (done && op == OP_ACC_LIT |-> acc_o == hwdata_i[7:0])
		else $error("acc literal");
	AST_BANK: assert property (done && op == OP_BANK_LIT |-> bank_select_register_o == hwdata_i[4:0])
		else $error("bank literal");
	AST_LATCH: assert property (done && op == OP_LATCH_LIT |-> program_counter_high_latch_o == hwdata_i[6:0])
		else $error("latch literal");
	AST_LIT_FLAGS: assert property (done && lit && ok_q |-> carry_o == c_q && zero_o == z_q)
		else $error("literal flags");
	AST_LSR: assert property (done && op == OP_LSR && d0 |-> ##2 !acc_o[7] && zero_o == (acc_o == 8'h00))
		else $error("shift result");
	AST_MOVE_Z: assert property (done && op == OP_MOVE && d0 |-> ##2 zero_o == (acc_o == 8'h00))
		else $error("move zero");
	AST_IND_Z: assert property (done && ind |-> ##2 zero_o == (acc_o == 8'h00))
		else $error("indirect zero");
	AST_WAIT: assert property (take |=> !hreadyout_o ##[1:8] hreadyout_o)
		else $error("bus wait");
	// Main scenarios
	C_LSR: cover property (done && op == OP_LSR);
	C_REL: cover property (done && op == OP_IND_REL);
	C_LIT: cover property (done && lit && ok_q);
endmodule : smie_core_asserts

bind smie_core smie_core_asserts u_asserts (
	.clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
	.hreadyout_o, .acc_o, .bank_select_register_o, .program_counter_high_latch_o,
	.carry_o, .zero_o
);

/* smie_prog_model.sv */
// Program image model packing command words
module smie_prog_model (
	input wire logic [smie_pkg::OP_W-1:0] op_i, // Op
	input wire logic [smie_pkg::BYTE_W-1:0] k_i, // Literal or file
	input wire logic d_i, // Destination
	input wire logic n_i, // Pointer select
	input wire logic [smie_pkg::MM_W-1:0] mm_i, // Mode
	input wire logic [smie_pkg::OFS_W-1:0] ofs_i, // Offset
	output logic [smie_pkg::DATA_W-1:0] word_o // Word
);
	timeunit 1ns;
	timeprecision 100ps;
	import smie_pkg::*;
	logic [BYTE_W-1:0] kf;
	// Narrow fields; unused bits packed as zero
	always_comb begin
		kf = k_i & 8'h7f;
		if (op_i == OP_BANK_LIT) kf = k_i & 8'h1f;
		if (op_i == OP_ACC_LIT) kf = k_i;
		word_o = {9'h000, op_i, 2'h0, ofs_i, mm_i, n_i, d_i, kf};
	end
endmodule : smie_prog_model

/* tb_smie_core.sv */
// Testbench for the execution block
module tb_smie_core;
	timeunit 1ns;
	timeprecision 100ps;
	import smie_pkg::*;
	logic clock_i, rst_n_i, hsel_i, hwrite_i, p_d, p_n;
	logic [7:0] haddr_i, p_k;
	logic [1:0] htrans_i, p_mm;
	logic [31:0] hwdata_i, p_word;
	logic [2:0] p_op;
	logic [5:0] p_ofs;
	wire [31:0] hrdata_o;
	wire hreadyout_o, hresp_o, carry_o, zero_o;
	wire [7:0] acc_o;
	wire [4:0] bank_select_register_o;
	wire [6:0] program_counter_high_latch_o;
	int n_errors = 0;
	int n_checks = 0;
	smie_core u_dut (.clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .acc_o, .bank_select_register_o, .program_counter_high_latch_o,
		.carry_o, .zero_o);
	smie_prog_model u_prog (.op_i(p_op), .k_i(p_k), .d_i(p_d), .n_i(p_n),
		.mm_i(p_mm), .ofs_i(p_ofs), .word_o(p_word));
	// Clock
	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end
	task automatic tally_and_finish();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_errors++;
		end
	endtask : chk
	// Bounded wait for a ready edge
	task automatic wait_rdy();
		@(negedge clock_i);
		for (int i = 0; i < 20 && hreadyout_o !== 1'b1; i++) @(negedge clock_i);
		if (hreadyout_o !== 1'b1) begin
			n_errors++;
			tally_and_finish();
		end
		@(posedge clock_i);
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= 2'h2;
		wait_rdy();
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_rdy();
		rd = hrdata_o;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
		chk({31'h0, hresp_o}, {31'h0, HRESP_OKAY});
	endtask : rc
	task automatic mem(input logic [31:0] a, input logic [31:0] d);
		wr(REG_MEMADDR, a);
		wr(REG_MEMDATA, d);
	endtask : mem
	task automatic cmd(input logic [2:0] op, input logic [7:0] k, input logic d = 0,
		input logic n = 0, input logic [1:0] mm = 0, input logic [5:0] ofs = 0);
		p_op = op;
		p_k = k;
		p_d = d;
		p_n = n;
		p_mm = mm;
		p_ofs = ofs;
		// Let the packed word settle, then drive on an edge
		@(posedge clock_i);
		wr(REG_CMD, p_word);
	endtask : cmd
	task automatic t_reset();
		rc(REG_ACC, 32'h0);
		rc(REG_PTR0, 32'h0);
		rc(REG_STATUS, 32'h0);
		rc(REG_BANK, 32'h0);
		rc(REG_LATCH, 32'h0);
		rc(REG_PTR1, 32'h0);
		rc(REG_MEMADDR, 32'h0);
		rc(8'h3c, 32'h0);
	endtask : t_reset
	task automatic t_lit();
		wr(REG_STATUS, 32'h3);
		cmd(OP_LATCH_LIT, 8'hff);
		rc(REG_LATCH, 32'h7f);
		rc(REG_STATUS, 32'h3);
		cmd(OP_ACC_LIT, 8'hff);
		rc(REG_ACC, 32'hff);
		rc(REG_STATUS, 32'h3);
		cmd(OP_BANK_LIT, 8'h0f);
		rc(REG_BANK, 32'hf);
	endtask : t_lit
	task automatic t_lsr();
		mem(32'h7ff, 32'h81);
		cmd(OP_LSR, 8'h7f);
		rc(REG_ACC, 32'h40);
		rc(REG_STATUS, 32'h1);
		mem(32'h7ff, 32'h01);
		cmd(OP_LSR, 8'h7f, 1);
		rc(REG_MEMDATA, 32'h0);
		rc(REG_ACC, 32'h40);
		rc(REG_STATUS, 32'h3);
	endtask : t_lsr
	task automatic t_move();
		wr(REG_STATUS, 32'h0);
		cmd(OP_MOVE, 8'h7f, 1);
		rc(REG_STATUS, 32'h2);
		rc(REG_ACC, 32'h40);
		mem(32'h123, 32'h5a);
		wr(REG_PTR1, 32'h123);
		cmd(OP_MOVE, 8'h01);
		rc(REG_ACC, 32'h5a);
		rc(REG_STATUS, 32'h0);
	endtask : t_move
	task automatic t_ind();
		logic [7:0] ea[4] = '{8'h33, 8'h11, 8'h22, 8'h22};
		logic [15:0] ep[4] = '{16'h0101, 16'h00ff, 16'h0101, 16'h00ff};
		mem(32'hff, 32'h11);
		mem(32'h100, 32'h22);
		mem(32'h101, 32'h33);
		mem(32'h0, 32'h0);
		for (int m = 0; m < 4; m++) begin
			wr(REG_PTR0, 32'h100);
			cmd(OP_IND_LOAD, 8'h00, 0, 0, m[1:0]);
			rc(REG_ACC, {24'h0, ea[m]});
			rc(REG_PTR0, {16'h0, ep[m]});
		end
		wr(REG_PTR1, 32'hffff);
		cmd(OP_IND_LOAD, 8'h00, 0, 1, MM_PRE_INC);
		rc(REG_PTR1, 32'h0);
		rc(REG_STATUS, 32'h2);
		cmd(OP_IND_LOAD, 8'h00, 0, 1, MM_POST_DEC);
		rc(REG_PTR1, 32'hffff);
		wr(REG_PTR1, 32'h120);
		cmd(OP_IND_REL, 8'h00, 0, 1, 2'h0, 6'h20);
		rc(REG_ACC, 32'h22);
		rc(REG_PTR1, 32'h120);
		rc(REG_STATUS, 32'h0);
	endtask : t_ind
	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		hsel_i = 1'b1;
		haddr_i = 8'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		t_reset();
		t_lit();
		t_lsr();
		t_move();
		t_ind();
		// Reset again mid-run and recheck the reset values
		rst_n_i <= 1'b0;
		@(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		t_reset();
		tally_and_finish();
	end
endmodule : tb_smie_core
